// >>> inc/imu_seq_pkg.sv
// Purpose: Shared constants and types for the inertial output sequencer.
// Assumes: One 20 MHz system clock; sensor front end delivers one sample set per internal tick.
// Notes:   Datagram bodies, CRC and serial framing live in the transmitter, not here.
package imu_seq_pkg;
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned SAMPLE_HZ      = 2000;
   localparam int unsigned TICK_CYCLES    = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned GYRO_DELAY_US  = 4500;
   localparam int unsigned GYRO_DELAY_TKS = (GYRO_DELAY_US * SAMPLE_HZ) / 1_000_000;
   localparam int unsigned STAB_TICKS     = 2000;
   localparam int unsigned SAMPLE_W       = 24;
   localparam int unsigned SUM_W          = 36;
   localparam int unsigned K0_FRAC        = 12;
   localparam logic [15:0] K0_Q12         = 16'h9ce7;  // 9.80665 in 4.12 fixed point.
   localparam int unsigned AUX_GAIN_FRAC  = 16;
   localparam int unsigned ACC_INT_W0     = 20;
   localparam int unsigned STATUS_STARTUP = 6;
   localparam logic [1:0]  UNIT_PLAIN     = 2'h0;
   localparam logic [1:0]  UNIT_INCR      = 2'h1;
   localparam logic [1:0]  UNIT_AVG       = 2'h2;
   localparam logic [1:0]  UNIT_INTEG     = 2'h3;
   localparam int unsigned GYRO_DLY_BIT   = 3;
   localparam logic [2:0]  DG_MEAS        = 3'h0;
   localparam logic [2:0]  DG_PART        = 3'h1;
   localparam logic [2:0]  DG_SERIAL      = 3'h2;
   localparam logic [2:0]  DG_CONFIG      = 3'h3;
   localparam logic [2:0]  DG_BIAS        = 3'h4;

   typedef enum logic [4:0] {
      M_SETTLE = 5'h01,
      M_SYNC   = 5'h02,
      M_SEND   = 5'h04,
      M_NORMAL = 5'h08,
      M_MAINT  = 5'h10
   } mode_t;

   typedef struct packed {
      logic signed [23:0] gyro;
      logic signed [23:0] acc;
      logic signed [23:0] aux;
      logic        [7:0]  aux_status;
   } sample_t;

   typedef struct packed {
      logic [10:0] rate_div;     // Internal ticks per output, 2000 / output rate.
      logic        triggered;
      logic        bias_trim_en;
      logic [3:0]  gyro_unit;
      logic [1:0]  acc_unit;
      logic [1:0]  acc_range;
      logic [3:0]  aux_bw_shift;
   } cfg_t;

   typedef struct packed {
      logic signed [23:0] gyro;
      logic signed [23:0] acc;
      logic signed [23:0] aux;
      logic        [7:0]  aux_status;
      logic        [7:0]  status;
   } meas_t;
endpackage

// >>> hw/imu_output_sequencer.sv
// Purpose: Mode sequencing, strobe timing and output conversion of the inertial unit.
// Assumes: Transmitter reports tx_done when its last bit has left the line.
// Notes:   An output event that finds the transmitter busy is dropped, not queued.
`timescale 1ns/1ps
`default_nettype none
module imu_output_sequencer
   import imu_seq_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES,
   parameter int unsigned STAB_TKS = STAB_TICKS
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               reset,
   // Pins from the host
   input  wire logic               reset_pin_low,
   input  wire logic               transmit_request_input,
   // Command decoder and configuration
   input  wire cfg_t               cfg,
   input  wire logic               reset_cmd,
   input  wire logic               special_req,
   input  wire logic [2:0]         special_kind,
   input  wire logic               maintenance_enter,
   input  wire logic               maintenance_exit,
   input  wire logic               maintenance_exit_to_init,
   input  wire logic signed [23:0] aux_gain,
   input  wire logic signed [23:0] aux_offset,
   // Sensor front end
   input  wire sample_t            sample,
   input  wire logic [7:0]         err_flags,
   input  wire logic               ref_ready,
   input  wire logic               chan_synced,
   // Transmitter
   input  wire logic               tx_done,
   output logic                    dg_start,
   output logic [2:0]              dg_kind,
   output meas_t                   meas,
   // Status
   output logic                    validity_strobe,
   output logic                    chan_sync_req,
   output logic                    startup_flag,
   output logic [4:0]              mode
);

   localparam int unsigned TCW = $clog2(TICK_CYC + 1);
   localparam int unsigned SCW = $clog2(STAB_TKS + 1);
   localparam int unsigned DLY = GYRO_DELAY_TKS;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] rst_s_reg, rst_s_next, trg_s_reg, trg_s_next;
   logic       rst_lvl_reg, rst_lvl_next, trg_lvl_reg, trg_lvl_next;
   logic       trg_fall;

   // A pin level is accepted only once the second and third stages agree.
   always_comb begin
      rst_s_next   = {rst_s_reg[1:0], reset_pin_low};
      trg_s_next   = {trg_s_reg[1:0], transmit_request_input};
      rst_lvl_next = (rst_s_reg[1] == rst_s_reg[2]) ? rst_s_reg[2] : rst_lvl_reg;
      trg_lvl_next = (trg_s_reg[1] == trg_s_reg[2]) ? trg_s_reg[2] : trg_lvl_reg;
   end

   // Both pins idle high through their pull-ups, so reset to high.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rst_s_reg   <= 3'h7;
         trg_s_reg   <= 3'h7;
         rst_lvl_reg <= 1'b1;
         trg_lvl_reg <= 1'b1;
      end else begin
         rst_s_reg   <= rst_s_next;
         trg_s_reg   <= trg_s_next;
         rst_lvl_reg <= rst_lvl_next;
         trg_lvl_reg <= trg_lvl_next;
      end
   end

   assign trg_fall = trg_lvl_reg & ~trg_lvl_next;

   // ------------------------------------------------------------
   // Internal sample tick and output period
   // ------------------------------------------------------------
   logic           hard_rst;
   logic [TCW-1:0] tcnt_reg, tcnt_next;
   logic           tick_reg, tick_next;
   logic [10:0]    ph_reg, ph_next;
   logic           wrap;

   assign hard_rst = reset | ~rst_lvl_reg;

   // The tick runs at 2000 per second in every mode, whatever the output rate.
   always_comb begin
      tick_next = (tcnt_reg == TCW'(TICK_CYC - 1));
      tcnt_next = tick_next ? '0 : tcnt_reg + 1'b1;
      wrap      = 1'b0;
      ph_next   = ph_reg;
      if (tick_reg) begin
         wrap    = (ph_reg >= cfg.rate_div - 11'h001);
         ph_next = wrap ? 11'h000 : ph_reg + 11'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (hard_rst) begin
         tcnt_reg <= '0;
         tick_reg <= 1'b0;
         ph_reg   <= 11'h000;
      end else begin
         tcnt_reg <= tcnt_next;
         tick_reg <= tick_next;
         ph_reg   <= ph_next;
      end
   end

   // ------------------------------------------------------------
   // Mode controller and strobe
   // ------------------------------------------------------------
   mode_t          st_reg, st_next;
   logic [1:0]     idx_reg, idx_next;
   logic           busy_reg, busy_next, pend_reg, pend_next;
   logic [2:0]     pkind_reg, pkind_next, kind_reg, kind_next;
   logic           start_reg, start_next, tov_reg, tov_next;
   logic           sync_reg, sync_next, up_reg, up_next;
   logic [SCW-1:0] stab_reg, stab_next;
   logic           out_evt, soft_clr;
   logic [1:0]     last_idx;
   logic [2:0]     init_kind;

   assign last_idx = cfg.bias_trim_en ? 2'h3 : 2'h2;

   // Init datagram order is fixed; their kinds differ from the measurement kind.
   always_comb begin
      case (idx_reg)
         2'h0:    init_kind = DG_PART;
         2'h1:    init_kind = DG_SERIAL;
         2'h2:    init_kind = DG_CONFIG;
         default: init_kind = DG_BIAS;
      endcase
   end

   // Errors never gate the output event, they only reach the status byte.
   assign out_evt = (st_reg == M_NORMAL) & (cfg.triggered ? trg_fall : wrap);

   always_comb begin
      st_next    = st_reg;
      idx_next   = idx_reg;
      busy_next  = busy_reg & ~tx_done;
      kind_next  = kind_reg;
      start_next = 1'b0;
      sync_next  = 1'b0;
      tov_next   = tov_reg;
      up_next    = up_reg;
      stab_next  = stab_reg;
      soft_clr   = 1'b0;
      pend_next  = pend_reg;
      pkind_next = pkind_reg;
      if (tx_done && !cfg.triggered) begin
         tov_next = 1'b1;
      end
      if (cfg.triggered && !tov_reg) begin
         tov_next = 1'b1;
      end
      case (st_reg)
         M_SETTLE: begin
            if (ref_ready) begin
               sync_next = 1'b1;
               st_next   = M_SYNC;
            end
         end
         M_SYNC: begin
            if (chan_synced && !busy_reg) begin  // A datagram still on the line would count as an init one.
               st_next  = M_SEND;
               idx_next = 2'h0;
            end
         end
         M_SEND: begin
            if (!busy_reg) begin
               start_next = 1'b1;
               kind_next  = init_kind;
               busy_next  = 1'b1;
            end else if (tx_done) begin
               if (idx_reg == last_idx) begin
                  st_next   = M_NORMAL;
                  up_next   = 1'b1;
                  stab_next = '0;
               end else begin
                  idx_next = idx_reg + 2'h1;
               end
            end
         end
         M_NORMAL: begin
            if (up_reg && tick_reg) begin
               if (stab_reg == SCW'(STAB_TKS - 1)) begin
                  up_next = 1'b0;
               end else begin
                  stab_next = stab_reg + 1'b1;
               end
            end
            if (out_evt && !busy_reg && !reset_cmd) begin
               start_next = 1'b1;
               busy_next  = 1'b1;
               tov_next   = 1'b0;
               kind_next  = pend_reg ? pkind_reg : DG_MEAS;
               pend_next  = 1'b0;
            end
            if (special_req) begin
               pend_next  = 1'b1;
               pkind_next = special_kind;
            end
            if (reset_cmd) begin
               st_next   = M_SETTLE;
               soft_clr  = 1'b1;
               pend_next = 1'b0;
            end else if (maintenance_enter) begin
               st_next = M_MAINT;
            end
         end
         M_MAINT: begin
            if (maintenance_exit) begin
               if (maintenance_exit_to_init) begin
                  st_next  = M_SETTLE;
                  soft_clr = 1'b1;
               end else begin
                  st_next = M_NORMAL;
                  up_next = 1'b0;
               end
            end
         end
         default: begin
            st_next = M_SETTLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (hard_rst) begin
         st_reg    <= M_SETTLE;
         idx_reg   <= 2'h0;
         busy_reg  <= 1'b0;
         pend_reg  <= 1'b0;
         pkind_reg <= DG_MEAS;
         kind_reg  <= DG_MEAS;
         start_reg <= 1'b0;
         tov_reg   <= 1'b1;
         sync_reg  <= 1'b0;
         up_reg    <= 1'b0;
         stab_reg  <= '0;
      end else begin
         st_reg    <= st_next;
         idx_reg   <= idx_next;
         busy_reg  <= busy_next;
         pend_reg  <= pend_next;
         pkind_reg <= pkind_next;
         kind_reg  <= kind_next;
         start_reg <= start_next;
         tov_reg   <= tov_next;
         sync_reg  <= sync_next;
         up_reg    <= up_next;
         stab_reg  <= stab_next;
      end
   end

   // ------------------------------------------------------------
   // Sample conversion
   // ------------------------------------------------------------
   logic signed [23:0]      dly_reg [DLY], dly_next [DLY];
   logic signed [SUM_W-1:0] gsum_reg, gsum_next, asum_reg, asum_next, aint_reg, aint_next;
   logic signed [23:0]      gint_reg, gint_next, filt_reg, filt_next, gsel;
   logic signed [SUM_W-1:0] gavg, aavg;
   logic signed [SUM_W+15:0] ainc;
   logic signed [47:0]      aux_prod;
   logic signed [23:0]      aux_comp, aint_wrap, g_out, a_out;
   logic [4:0]              ish;
   meas_t                   meas_reg, meas_next;
   logic                    clr;

   assign clr = out_evt | soft_clr;

   // Gyro delay line shifts once per tick; unit codes of eight and above tap its end.
   always_comb begin
      for (int i = 0; i < DLY; i++) begin
         dly_next[i] = dly_reg[i];
         if (tick_reg) begin
            dly_next[i] = (i == 0) ? sample.gyro : dly_reg[(i == 0) ? 0 : i - 1];
         end
      end
      gsel = cfg.gyro_unit[GYRO_DLY_BIT] ? dly_reg[DLY-1] : sample.gyro;
   end

   // Window sums restart at each output event; integrators only on reset or a maintenance exit to init.
   always_comb begin
      gsum_next = (clr ? '0 : gsum_reg) + (tick_reg ? SUM_W'(gsel) : '0);
      asum_next = (clr ? '0 : asum_reg) + (tick_reg ? SUM_W'(sample.acc) : '0);
      gint_next = (soft_clr ? '0 : gint_reg) + (tick_reg ? gsel : 24'sh000000);
      aint_next = (soft_clr ? '0 : aint_reg) + (tick_reg ? SUM_W'(sample.acc) : '0);
      filt_next = filt_reg;
      if (tick_reg) begin
         filt_next = filt_reg + ((sample.aux - filt_reg) >>> cfg.aux_bw_shift);
      end
   end

   // Division by the tick count costs a wide divider but keeps any output rate exact.
   always_comb begin
      gavg      = gsum_reg / $signed({1'b0, cfg.rate_div});
      aavg      = asum_reg / $signed({1'b0, cfg.rate_div});
      ainc      = asum_reg * $signed({1'b0, K0_Q12});
      aux_prod  = filt_reg * aux_gain;
      aux_comp  = 24'(aux_prod >>> AUX_GAIN_FRAC) + aux_offset;
      ish       = 5'(SAMPLE_W - ACC_INT_W0) - ((cfg.acc_range == 2'h3) ? 5'h4 : {3'h0, cfg.acc_range});
      aint_wrap = ($signed(aint_reg[23:0]) <<< ish) >>> ish;
      case (cfg.gyro_unit[1:0])
         UNIT_INCR:  g_out = gsum_reg[23:0];
         UNIT_AVG:   g_out = gavg[23:0];
         UNIT_INTEG: g_out = gint_reg;
         default:    g_out = gsel;
      endcase
      case (cfg.acc_unit)
         UNIT_INCR:  a_out = ainc[K0_FRAC +: 24];
         UNIT_AVG:   a_out = aavg[23:0];
         UNIT_INTEG: a_out = aint_wrap;
         default:    a_out = sample.acc;
      endcase
      meas_next = meas_reg;
      if (out_evt) begin
         meas_next.gyro       = g_out;
         meas_next.acc        = a_out;
         meas_next.aux        = aux_comp;
         meas_next.aux_status = sample.aux_status;
         meas_next.status     = err_flags;
         meas_next.status[STATUS_STARTUP] = up_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (hard_rst) begin
         for (int i = 0; i < DLY; i++) begin
            dly_reg[i] <= 24'sh000000;
         end
         gsum_reg <= '0;
         asum_reg <= '0;
         aint_reg <= '0;
         gint_reg <= 24'sh000000;
         filt_reg <= 24'sh000000;
         meas_reg <= '0;
      end else begin
         dly_reg  <= dly_next;
         gsum_reg <= gsum_next;
         asum_reg <= asum_next;
         aint_reg <= aint_next;
         gint_reg <= gint_next;
         filt_reg <= filt_next;
         meas_reg <= meas_next;
      end
   end

   // Outputs, each straight from a flip-flop.
   assign dg_start        = start_reg;
   assign dg_kind         = kind_reg;
   assign meas            = meas_reg;
   assign validity_strobe = tov_reg;
   assign chan_sync_req   = sync_reg;
   assign startup_flag    = up_reg;
   assign mode            = st_reg;

endmodule // imu_output_sequencer
`default_nettype wire

// >>> dv/imu_seq_asserts.sv
// Purpose: Port checks for the output sequencer.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Bound to the design top and watches only its ports.
`timescale 1ns/1ps
`default_nettype none
module imu_seq_asserts
   import imu_seq_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES,
   parameter int unsigned STAB_TKS = STAB_TICKS
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Inputs
   input wire logic       reset_pin_low,
   input wire cfg_t       cfg,
   input wire logic       reset_cmd,
   input wire logic       ref_ready,
   input wire logic       chan_synced,
   input wire logic       tx_done,
   // Outputs
   input wire logic       dg_start,
   input wire logic [2:0] dg_kind,
   input wire logic       validity_strobe,
   input wire logic       chan_sync_req,
   input wire logic       startup_flag,
   input wire logic [4:0] mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Shadows of the line and the reset pin keep init checks quiet while a datagram drains or the pin holds.
   logic       line_busy;
   logic [3:0] pin_hist;
   logic       pin_ok;
   always_ff @(posedge clk_sys) begin
      pin_hist <= {pin_hist[2:0], reset_pin_low};
      if (reset) begin
         line_busy <= 1'b0;
      end else if (dg_start) begin
         line_busy <= 1'b1;
      end else if (tx_done) begin
         line_busy <= 1'b0;
      end
   end
   assign pin_ok = reset_pin_low && (&pin_hist);
   // Init steps are named so the order reads like the mode walk.
   sequence settled_s; mode == 5'h01 && ref_ready && pin_ok; endsequence
   sequence sync_s; chan_sync_req && mode == 5'h02; endsequence
   sequence first_s; mode == 5'h04 ##1 dg_start && dg_kind == DG_PART; endsequence
   init_sync_a: assert property (settled_s |=> sync_s)
      else $error("no channel sync after settle");
   init_send_a: assert property (mode == 5'h02 && chan_synced && !line_busy && pin_ok |=> first_s)
      else $error("part datagram not first");
   init_kind_a: assert property (dg_start && mode == 5'h04 |-> dg_kind != DG_MEAS)
      else $error("init datagram of measurement kind");
   strobe_fall_a: assert property ($fell(validity_strobe) |-> dg_start && $past(mode) == 5'h08)
      else $error("strobe fell without an output");
   // The mode and trigger terms keep resets and mode switches out of the hold.
   strobe_hold_a: assert property (!validity_strobe && !tx_done && !cfg.triggered
      |=> !validity_strobe || mode != 5'h08 || cfg.triggered) else $error("strobe rose early");
   trig_edge_a: assert property (cfg.triggered && $fell(validity_strobe) |=> validity_strobe)
      else $error("triggered strobe wider than one cycle");
   startup_set_a: assert property ($past(mode) == 5'h04 && mode == 5'h08 |-> startup_flag)
      else $error("startup flag clear after init");
   maint_skip_a: assert property ($past(mode) == 5'h10 && mode == 5'h08 |-> !startup_flag)
      else $error("startup flag set after maintenance");
   cmd_reset_a: assert property (mode == 5'h08 && reset_cmd |-> ##[1:3] mode == 5'h01)
      else $error("reset command ignored");
   pin_reset_a: assert property (!reset_pin_low [*4] |-> ##[1:2] mode == 5'h01)
      else $error("reset pin ignored");
endmodule // imu_seq_asserts
bind imu_output_sequencer imu_seq_asserts #(.TICK_CYC(TICK_CYC), .STAB_TKS(STAB_TKS)) chk_u (
   .clk_sys(clk_sys), .reset(reset), .reset_pin_low(reset_pin_low), .cfg(cfg), .reset_cmd(reset_cmd),
   .ref_ready(ref_ready), .chan_synced(chan_synced), .tx_done(tx_done), .dg_start(dg_start),
   .dg_kind(dg_kind), .validity_strobe(validity_strobe), .chan_sync_req(chan_sync_req),
   .startup_flag(startup_flag), .mode(mode));
`default_nettype wire

// >>> dv/imu_host_model.sv
// Purpose: Host and transmitter stand-in that takes datagrams.
// Assumes: Each datagram occupies the line for TX_CYC cycles.
// Notes:   Kinds are logged so the bench can check their order.
`timescale 1ns/1ps
`default_nettype none
module imu_host_model
   import imu_seq_pkg::*;
#(
   parameter int unsigned TX_CYC = 5
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Datagram side
   input wire logic       dg_start,
   input wire logic [2:0] dg_kind,
   output var logic       tx_done
);
   int left;
   logic [2:0] kinds[$];
   initial tx_done = 1'b0;
   // Last-bit pulse ends each datagram; a new start restarts the count.
   always @(posedge clk_sys) begin
      tx_done <= 1'b0;
      if (reset) begin
         left <= 0;
      end else if (dg_start) begin
         left <= TX_CYC;
         kinds.push_back(dg_kind);
      end else if (left == 1) begin
         tx_done <= 1'b1;
         left <= 0;
      end else if (left > 1) begin
         left <= left - 1;
      end
   end
endmodule // imu_host_model
`default_nettype wire

// >>> dv/test_imu_output_sequencer.sv
// Purpose: Directed bench of the output sequencer.
// Assumes: Short tick and startup counts so the run stays brief.
// Notes:   Inputs change at the falling edge only.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t mismatch", $time); end end
module test_imu_output_sequencer;
   import imu_seq_pkg::*;
   logic clk_sys = 1'b0, reset = 1'b1, reset_pin_low = 1'b1, transmit_request_input = 1'b1;
   logic reset_cmd = 1'b0, special_req = 1'b0, maintenance_enter = 1'b0, maintenance_exit = 1'b0;
   logic maintenance_exit_to_init = 1'b0, ref_ready = 1'b0, chan_synced = 1'b1, tx_done;
   logic [2:0] special_kind = 3'h0, dg_kind;
   logic signed [23:0] aux_gain = 24'sh010000, aux_offset = 24'sh000003, g1, a1;
   logic [7:0] err_flags = 8'h05;
   cfg_t cfg = '0;
   sample_t sample = '0;
   meas_t meas;
   logic dg_start, validity_strobe, chan_sync_req, startup_flag;
   logic [4:0] mode;
   int failures = 0, compares = 0;
   time t1;
   always #25 clk_sys = ~clk_sys;
   imu_output_sequencer #(.TICK_CYC(8), .STAB_TKS(4)) dut_u (.clk_sys(clk_sys), .reset(reset),
      .reset_pin_low(reset_pin_low), .transmit_request_input(transmit_request_input), .cfg(cfg),
      .reset_cmd(reset_cmd), .special_req(special_req), .special_kind(special_kind),
      .maintenance_enter(maintenance_enter), .maintenance_exit(maintenance_exit),
      .maintenance_exit_to_init(maintenance_exit_to_init), .aux_gain(aux_gain), .aux_offset(aux_offset),
      .sample(sample), .err_flags(err_flags), .ref_ready(ref_ready), .chan_synced(chan_synced),
      .tx_done(tx_done), .dg_start(dg_start), .dg_kind(dg_kind), .meas(meas),
      .validity_strobe(validity_strobe), .chan_sync_req(chan_sync_req), .startup_flag(startup_flag),
      .mode(mode));
   imu_host_model #(.TX_CYC(5)) host_u (.clk_sys(clk_sys), .reset(reset), .dg_start(dg_start),
      .dg_kind(dg_kind), .tx_done(tx_done));
   task automatic give_verdict();
      if (failures == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Every wait is bounded; running out ends the run as a mismatch.
   task automatic wait_mode(input logic [4:0] m);
      for (int i = 0; i < 2000 && mode !== m; i++) @(negedge clk_sys);
      if (mode !== m) begin failures++; $display("[ERR] %0t mode wait timed out", $time); give_verdict(); end
   endtask
   task automatic wait_start();
      @(negedge clk_sys);
      for (int i = 0; i < 400 && dg_start !== 1'b1; i++) @(negedge clk_sys);
      if (dg_start !== 1'b1) begin failures++; $display("[ERR] %0t no datagram", $time); give_verdict(); end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask
   // Holding ref_ready low keeps the settle state visible for one check.
   task automatic to_init(ref logic s);
      ref_ready = 1'b0;
      pulse(s);
      wait_mode(5'h01);
      host_u.kinds.delete();
      ref_ready = 1'b1;
      wait_mode(5'h08);
      `CHK(host_u.kinds.size(), 3)
   endtask
   initial begin
      cfg.rate_div = 11'd2; cfg.bias_trim_en = 1'b1; cfg.gyro_unit = 4'h1; cfg.acc_unit = 2'h2;
      sample = '{gyro: 24'sd5, acc: 24'sd7, aux: 24'sd100, aux_status: 8'ha5};
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      ref_ready = 1'b1;
      wait_mode(5'h08);
      `CHK(host_u.kinds.size(), 4)
      for (int k = 0; k < 4; k++) `CHK(host_u.kinds[k], 3'(k + 1))
      `CHK(startup_flag, 1'b1)
      wait_start();
      `CHK(meas.status[6], 1'b1)
      for (int i = 0; i < 200 && startup_flag !== 1'b0; i++) @(negedge clk_sys);
      `CHK(startup_flag, 1'b0)
      // Window conversions over two ticks per output.
      repeat (2) wait_start();
      `CHK(meas.gyro, 24'sd10)
      `CHK(meas.acc, 24'sd7)
      `CHK(meas.aux, 24'sd103)
      `CHK(meas.status, 8'h05)
      `CHK(meas.aux_status, 8'ha5)
      // A step with shift one halves the gap per tick: one tick lands at 150 before the next latch.
      cfg.aux_bw_shift = 4'h1;
      sample.aux = 24'sd200;
      t1 = $time;
      wait_start();
      `CHK($time - t1, 64'd800)
      `CHK(meas.aux, 24'sd153)
      `CHK(validity_strobe, 1'b0)
      repeat (4) @(negedge clk_sys);
      `CHK(validity_strobe, 1'b0)
      repeat (5) @(negedge clk_sys);
      `CHK(validity_strobe, 1'b1)
      cfg.acc_unit = 2'h1;
      cfg.gyro_unit = 4'h9;
      repeat (2) wait_start();
      `CHK(meas.acc, 24'sd137)
      sample.gyro = 24'sd1;
      wait_start();
      `CHK(meas.gyro, 24'sd10)
      cfg.gyro_unit = 4'h3;
      cfg.acc_unit = 2'h3;
      repeat (3) wait_start();
      g1 = meas.gyro;
      a1 = meas.acc;
      wait_start();
      `CHK(24'(meas.gyro - g1), 24'sd2)
      `CHK(24'(meas.acc - a1), 24'sd14)
      for (int k = 1; k < 5; k++) begin
         wait_start();
         special_kind = 3'(k);
         pulse(special_req);
         wait_start();
         `CHK(dg_kind, 3'(k))
      end
      cfg.bias_trim_en = 1'b0;
      to_init(reset_cmd);
      // Leave straight to normal while the startup flag still stands, so clearing it is seen.
      `CHK(startup_flag, 1'b1)
      pulse(maintenance_enter);
      wait_mode(5'h10);
      pulse(maintenance_exit);
      wait_mode(5'h08);
      `CHK(startup_flag, 1'b0)
      pulse(maintenance_enter);
      wait_mode(5'h10);
      maintenance_exit_to_init = 1'b1;
      to_init(maintenance_exit);
      reset_pin_low = 1'b0;
      repeat (6) @(negedge clk_sys);
      `CHK(mode, 5'h01)
      reset_pin_low = 1'b1;
      wait_mode(5'h08);
      cfg.triggered = 1'b1;
      repeat (40) @(negedge clk_sys);
      t1 = host_u.kinds.size();
      transmit_request_input = 1'b0;
      wait_start();
      `CHK(dg_kind, DG_MEAS)
      repeat (2) @(negedge clk_sys);
      `CHK(validity_strobe, 1'b1)
      repeat (40) @(negedge clk_sys);
      `CHK(64'(host_u.kinds.size()), t1 + 1)
      give_verdict();
   end
endmodule // test_imu_output_sequencer
`default_nettype wire
